// ### qpd_instruction_decoder.sv
// Instruction decoder of a quad digital potentiometer with its wiper registers.
`timescale 1ns/100ps
`default_nettype none
`include "qpd_defs.svh"

// Overview of operation
// RULE1 - Four potentiometers, each with wiper register and data registers, picked by pot select.
// RULE2 - Opcode 1001 returns the selected wiper register; bank bits ignored.
// RULE3 - Opcode 1010 loads a master-supplied value into the selected wiper register.
// RULE4 - Opcode 1011 returns the data register picked by pot and bank select.
// RULE5 - Opcode 1100 stores a master-supplied value into the picked data register.
// RULE6 - Opcode 1101 copies the picked data register into that pot's wiper register.
// RULE7 - Opcode 1110 copies the selected wiper register into its bank-selected data register.
// RULE8 - Opcode 0001 copies each pot's bank-selected data register into its wiper register.
// RULE9 - Opcode 1000 copies every wiper register into its bank-selected data register.
// RULE10 - Opcode 0010 enables stepwise increment or decrement of the selected wiper register.
// RULE11 - Don't-care select bits never influence the result.
// RULE12 - Instruction byte is opcode, pot select, bank select, sent most significant first.
// RULE13 - Unassigned opcodes are ignored and change no register.
module qpd_instruction_decoder
  import qpd_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   rst,
  input  wire logic   linkClk,
  input  wire logic   linkFrame,
  input  wire logic   linkDataIn,
  output logic        linkDataOut,
  output logic        linkDataOe,
  output qpd_wipers_t wiperPos,
  output logic        busy
);

  ////////////////////////////////////////////////////////////////////////////////
  // Link input synchronisers and edge detection.

  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic       clkPrev_q;
  logic       clkS;
  logic       frameS;
  logic       dataS;
  logic       clkRise;
  logic       clkFall;

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_q   <= 3'h0;
      sync2_q   <= 3'h0;
      clkPrev_q <= 1'b0;
    end else begin
      sync1_q   <= {linkDataIn, linkFrame, linkClk};
      sync2_q   <= sync1_q;
      clkPrev_q <= sync2_q[0];
    end
  end

  assign clkS    = sync2_q[0];
  assign frameS  = sync2_q[1];
  assign dataS   = sync2_q[2];
  assign clkRise = clkS & ~clkPrev_q;
  assign clkFall = ~clkS & clkPrev_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Decoder state.

  qpd_state_t              state_q;
  qpd_state_t              state_d;
  qpd_instr_t              instr_q;
  qpd_instr_t              instr_d;
  logic [`QPD_CNT_W-1:0]   cnt_q;
  logic [`QPD_CNT_W-1:0]   cnt_d;
  logic [`QPD_INSTR_W-1:0] shift_q;
  logic [`QPD_INSTR_W-1:0] shift_d;
  logic [`QPD_INSTR_W-1:0] out_q;
  logic [`QPD_INSTR_W-1:0] out_d;
  logic                    dout_q;
  logic                    dout_d;
  logic [`QPD_SEL_W-1:0]   idx_q;
  logic [`QPD_SEL_W-1:0]   idx_d;
  qpd_wipers_t             wiper_q;
  qpd_wipers_t             wiper_d;

  logic                    memWrEn;
  logic [`QPD_ADDR_W-1:0]  memWrAddr;
  qpd_wiper_t              memWrData;
  logic [`QPD_ADDR_W-1:0]  memRdAddr;
  qpd_wiper_t              memRdData;
  logic [`QPD_INSTR_W-1:0] nextByte;

  assign nextByte = {shift_q[`QPD_INSTR_W-2:0], dataS};

  always_comb begin
    state_d   = state_q;
    instr_d   = instr_q;
    cnt_d     = cnt_q;
    shift_d   = shift_q;
    out_d     = out_q;
    dout_d    = dout_q;
    idx_d     = idx_q;
    wiper_d   = wiper_q;
    memWrEn   = 1'b0;
    memWrAddr = {idx_q, instr_q.bank};
    memWrData = wiper_q[idx_q];
    memRdAddr = {instr_q.pot, instr_q.bank};
    case (state_q)
      ST_IDLE: begin
        cnt_d  = 3'h0;
        dout_d = 1'b0;
        if (frameS) begin
          state_d = ST_OPCODE;
        end
      end
      ST_OPCODE: begin
        if (!frameS) begin
          state_d = ST_IDLE;
        end else if (clkRise) begin
          shift_d = nextByte;
          cnt_d   = cnt_q + 3'h1;
          if (cnt_q == `QPD_LAST_BIT) begin
            instr_d = qpd_instr_t'(nextByte); // [RULE12]
            state_d = ST_DECODE;
          end
        end
      end
      ST_DECODE: begin
        cnt_d = 3'h0;
        idx_d = 2'h0;
        case (instr_q.opcode)
          `QPD_OP_RD_WIPER: begin
            out_d   = {2'h0, wiper_q[instr_q.pot]}; // [RULE2] [RULE11]
            state_d = ST_READOUT;
          end
          `QPD_OP_WR_WIPER: begin
            state_d = ST_DATAIN; // [RULE3]
          end
          `QPD_OP_WR_DATA: begin
            state_d = ST_DATAIN; // [RULE5]
          end
          `QPD_OP_RD_DATA: begin
            state_d = ST_MEMRD; // [RULE4]
          end
          `QPD_OP_XFR_D2W: begin
            state_d = ST_MEMRD; // [RULE6]
          end
          `QPD_OP_XFR_W2D: begin
            memWrEn   = 1'b1; // [RULE7]
            memWrAddr = {instr_q.pot, instr_q.bank};
            memWrData = wiper_q[instr_q.pot];
            state_d   = ST_DONE;
          end
          `QPD_OP_GXFR_D2W: begin
            state_d = ST_GRD; // [RULE8]
          end
          `QPD_OP_GXFR_W2D: begin
            state_d = ST_GWR; // [RULE9]
          end
          `QPD_OP_INCDEC: begin
            state_d = ST_INCDEC; // [RULE10]
          end
          default: begin
            state_d = ST_DONE; // [RULE13]
          end
        endcase
      end
      ST_MEMRD: begin
        // Read data from the store is valid in this cycle.
        if (instr_q.opcode == `QPD_OP_RD_DATA) begin
          out_d   = {2'h0, memRdData}; // [RULE4]
          state_d = ST_READOUT;
        end else begin
          wiper_d[instr_q.pot] = memRdData; // [RULE6]
          state_d              = ST_DONE;
        end
      end
      ST_DATAIN: begin
        // A frame that ends before the value byte is complete changes nothing.
        if (!frameS) begin
          state_d = ST_IDLE;
        end else if (clkRise) begin
          shift_d = nextByte;
          cnt_d   = cnt_q + 3'h1;
          if (cnt_q == `QPD_LAST_BIT) begin
            state_d = ST_DONE;
            if (instr_q.opcode == `QPD_OP_WR_WIPER) begin
              wiper_d[instr_q.pot] = nextByte[`QPD_WIPER_W-1:0]; // [RULE3] [RULE11]
            end else begin
              memWrEn   = 1'b1; // [RULE5]
              memWrAddr = {instr_q.pot, instr_q.bank};
              memWrData = nextByte[`QPD_WIPER_W-1:0];
            end
          end
        end
      end
      ST_READOUT: begin
        // Bits change on the falling link edge so the master samples them stable.
        if (!frameS) begin
          state_d = ST_IDLE;
        end else if (clkFall) begin
          dout_d = out_q[`QPD_INSTR_W-1];
          out_d  = {out_q[`QPD_INSTR_W-2:0], 1'b0};
        end
      end
      ST_GRD: begin
        memRdAddr = {idx_q, instr_q.bank}; // [RULE8] [RULE11]
        state_d   = ST_GAPPLY;
      end
      ST_GAPPLY: begin
        wiper_d[idx_q] = memRdData; // [RULE8]
        idx_d          = idx_q + 2'h1;
        state_d        = (idx_q == `QPD_LAST_POT) ? ST_DONE : ST_GRD;
      end
      ST_GWR: begin
        memWrEn = 1'b1; // [RULE9] [RULE11]
        idx_d   = idx_q + 2'h1;
        if (idx_q == `QPD_LAST_POT) begin
          state_d = ST_DONE;
        end
      end
      ST_INCDEC: begin
        // Each link bit steps the wiper one tap; the ends saturate.
        if (!frameS) begin
          state_d = ST_IDLE;
        end else if (clkRise) begin
          if (dataS && (wiper_q[instr_q.pot] != `QPD_WIPER_MAX)) begin
            wiper_d[instr_q.pot] = wiper_q[instr_q.pot] + 6'h01; // [RULE10]
          end else if (!dataS && (wiper_q[instr_q.pot] != `QPD_WIPER_RST)) begin
            wiper_d[instr_q.pot] = wiper_q[instr_q.pot] - 6'h01; // [RULE10]
          end
        end
      end
      ST_DONE: begin
        // Extra bits in the same frame are ignored until the frame ends.
        if (!frameS) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      instr_q <= qpd_instr_t'(8'h00);
      cnt_q   <= 3'h0;
      shift_q <= 8'h00;
      out_q   <= 8'h00;
      dout_q  <= 1'b0;
      idx_q   <= 2'h0;
      wiper_q <= '0; // [RULE1]
    end else begin
      state_q <= state_d;
      instr_q <= instr_d;
      cnt_q   <= cnt_d;
      shift_q <= shift_d;
      out_q   <= out_d;
      dout_q  <= dout_d;
      idx_q   <= idx_d;
      wiper_q <= wiper_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Data register store and outputs.

  qpd_data_mem u_data_mem (
    .clk    (clk),
    .rst    (rst),
    .wrEn   (memWrEn),
    .wrAddr (memWrAddr),
    .wrData (memWrData),
    .rdAddr (memRdAddr),
    .rdData (memRdData)
  );

  assign linkDataOut = dout_q;
  assign linkDataOe  = (state_q == ST_READOUT);
  assign wiperPos    = wiper_q;
  assign busy        = (state_q == ST_DECODE) || (state_q == ST_MEMRD) ||
                       (state_q == ST_GRD) || (state_q == ST_GAPPLY) ||
                       (state_q == ST_GWR);

endmodule

`default_nettype wire

// ### qpd_defs.svh
// Constants of the quad potentiometer instruction decoder.
`ifndef QPD_DEFS_SVH
`define QPD_DEFS_SVH

// Instruction byte layout, most significant bit first on the link.
`define QPD_INSTR_W      8
`define QPD_OPCODE_W     4
`define QPD_SEL_W        2

// Opcode encodings.
`define QPD_OP_RD_WIPER  4'h9
`define QPD_OP_WR_WIPER  4'hA
`define QPD_OP_RD_DATA   4'hB
`define QPD_OP_WR_DATA   4'hC
`define QPD_OP_XFR_D2W   4'hD
`define QPD_OP_XFR_W2D   4'hE
`define QPD_OP_GXFR_D2W  4'h1
`define QPD_OP_GXFR_W2D  4'h8
`define QPD_OP_INCDEC    4'h2

// Potentiometer geometry.
`define QPD_NUM_POTS     4
`define QPD_WIPER_W      6
`define QPD_WIPER_MAX    6'h3F
`define QPD_WIPER_RST    6'h00
`define QPD_ADDR_W       4
`define QPD_DEPTH        16

// Bit and pot counter figures.
`define QPD_CNT_W        3
`define QPD_LAST_BIT     3'h7
`define QPD_LAST_POT     2'h3

`endif

// ### qpd_pkg.sv
// Types shared by the quad potentiometer instruction decoder.
`include "qpd_defs.svh"

package qpd_pkg;

  typedef struct packed {
    logic [`QPD_OPCODE_W-1:0] opcode;
    logic [`QPD_SEL_W-1:0]    pot;
    logic [`QPD_SEL_W-1:0]    bank;
  } qpd_instr_t;

  typedef logic [`QPD_WIPER_W-1:0] qpd_wiper_t;

  typedef logic [`QPD_NUM_POTS-1:0][`QPD_WIPER_W-1:0] qpd_wipers_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_OPCODE,
    ST_DECODE,
    ST_MEMRD,
    ST_DATAIN,
    ST_READOUT,
    ST_GRD,
    ST_GAPPLY,
    ST_GWR,
    ST_INCDEC,
    ST_DONE
  } qpd_state_t;

endpackage

// ### qpd_data_mem.sv
// Data register store: four banks for each of four potentiometers.
`timescale 1ns/100ps
`default_nettype none
`include "qpd_defs.svh"

module qpd_data_mem
  import qpd_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    wrEn,
  input  wire logic [`QPD_ADDR_W-1:0]  wrAddr,
  input  wire qpd_wiper_t              wrData,
  input  wire logic [`QPD_ADDR_W-1:0]  rdAddr,
  output qpd_wiper_t                   rdData
);

  // The array models stored cells, so it keeps its contents over reset.
  qpd_wiper_t mem_q [`QPD_DEPTH];
  qpd_wiper_t rdData_q;

  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem_q[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdData_q <= `QPD_WIPER_RST;
    end else begin
      rdData_q <= mem_q[rdAddr];
    end
  end

  assign rdData = rdData_q;

endmodule

`default_nettype wire

// ### qpd_decoder_asserts.sv
// Port checker of the quad potentiometer instruction decoder.
`timescale 1ns/100ps
`default_nettype none

module qpd_decoder_asserts
  import qpd_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        linkClk,
  input wire logic        linkFrame,
  input wire logic        linkDataIn,
  input wire logic        linkDataOut,
  input wire logic        linkDataOe,
  input wire qpd_wipers_t wiperPos,
  input wire logic        busy
);
  logic [4:0] idleCnt_q;
  logic [4:0] idleCnt_d;
  logic [4:0] busyCnt_q;
  logic [4:0] busyCnt_d;

  // The idle count saturates so that a long quiet spell never wraps back into a frame.
  always_comb begin
    idleCnt_d = linkFrame ? 5'h00 : ((idleCnt_q == 5'h1F) ? idleCnt_q : idleCnt_q + 5'h01);
    busyCnt_d = busy ? busyCnt_q + 5'h01 : 5'h00;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      idleCnt_q <= 5'h1F;
      busyCnt_q <= 5'h00;
    end else begin
      idleCnt_q <= idleCnt_d;
      busyCnt_q <= busyCnt_d;
    end
  end

  ////////////////////////////////////////
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);

  a_reset_clears: assert property (disable iff (1'b0)
    rst |=> wiperPos == '0 && !linkDataOe && !busy) else $error("reset state wrong");
  a_oe_in_frame: assert property (
    linkDataOe |-> idleCnt_q < 5'h06) else $error("read drive outside a frame");
  a_oe_holds: assert property (
    linkDataOe && linkFrame |=> linkDataOe) else $error("read drive dropped in frame");
  a_oe_after_decode: assert property (
    $rose(linkDataOe) |-> $past(busy) || $past(busy, 2)) else $error("read without decode");
  a_busy_not_oe: assert property (
    busy |-> !linkDataOe) else $error("busy while driving read data");
  a_busy_bounded: assert property (
    busyCnt_q < 5'h0D) else $error("busy too long");
  a_idle_not_busy: assert property (
    idleCnt_q > 5'h10 |-> !busy) else $error("busy long after frame");
  a_wiper_quiet: assert property (
    !$stable(wiperPos) && !$past(rst) |-> idleCnt_q < 5'h10) else $error("wiper moved idle");

  c_read: cover property ($rose(linkDataOe));
  c_busy: cover property ($rose(busy));
  c_wiper: cover property (!$stable(wiperPos));
endmodule

bind qpd_instruction_decoder qpd_decoder_asserts qpd_decoder_asserts_inst (
  .clk(clk), .rst(rst), .linkClk(linkClk), .linkFrame(linkFrame), .linkDataIn(linkDataIn),
  .linkDataOut(linkDataOut), .linkDataOe(linkDataOe), .wiperPos(wiperPos), .busy(busy));

`default_nettype wire

// ### qpd_link_master.sv
// Link master model that frames instructions and value bytes.
`timescale 1ns/100ps
`default_nettype none

module qpd_link_master (
  input  wire logic clk,
  output logic      linkClk,
  output logic      linkFrame,
  output logic      linkDataIn,
  input  wire logic linkDataOut
);
  initial begin
    linkClk = 1'b0;
    linkFrame = 1'b0;
    linkDataIn = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Read data is collected on every rising link edge; the last eight samples are returned.
  task automatic frame(input logic [7:0] ins, input logic [7:0] val, input int nBits,
                       output logic [7:0] rd);
    logic [15:0] sh;
    sh = {ins, val};
    rd = 8'h00;
    tick(1);
    linkFrame = 1'b1;
    tick(4);
    for (int i = 0; i < 8 + nBits; i++) begin
      linkDataIn = sh[15];
      sh = {sh[14:0], 1'b0};
      tick(4);
      linkClk = 1'b1;
      rd = {rd[6:0], linkDataOut};
      tick(4);
      linkClk = 1'b0;
    end
    tick(4);
    linkFrame = 1'b0;
    // A released line has no pull, so show the opposite of the last bit.
    linkDataIn = ~linkDataIn;
    tick(16);
  endtask
endmodule

`default_nettype wire

// ### tb.sv
// Testbench of the quad potentiometer instruction decoder.
`timescale 1ns/100ps
`default_nettype none

module tb
  import qpd_pkg::*;
;
  typedef struct {
    logic [7:0]  ins;
    logic [7:0]  val;
    int          nBits;
    qpd_wipers_t wp;
    logic [7:0]  rd;
  } qpd_row_t;

  logic        clk;
  logic        rst;
  logic        linkClk;
  logic        linkFrame;
  logic        linkDataIn;
  logic        linkDataOut;
  logic        linkDataOe;
  logic        busy;
  qpd_wipers_t wiperPos;
  logic [7:0]  rdByte;
  int          errCount;
  int          nTests;
  qpd_row_t    rows[$];
  logic [3:0]  badOps [7] = '{4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hF};

  qpd_instruction_decoder qpd_instruction_decoder_inst (
    .clk(clk), .rst(rst), .linkClk(linkClk), .linkFrame(linkFrame), .linkDataIn(linkDataIn),
    .linkDataOut(linkDataOut), .linkDataOe(linkDataOe), .wiperPos(wiperPos), .busy(busy));
  qpd_link_master qpd_link_master_inst (
    .clk(clk), .linkClk(linkClk), .linkFrame(linkFrame), .linkDataIn(linkDataIn),
    .linkDataOut(linkDataOut));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  ////////////////////////////////////////
  task automatic closeOut();
    $display("comparisons %0d mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic cmpWiper(input qpd_wipers_t exp);
    nTests++;
    if (wiperPos !== exp) begin
      errCount++;
      $display("wrong value wiperPos expected %h seen %h", exp, wiperPos);
    end
  endtask

  task automatic cmpByte(input logic [7:0] exp, input logic [7:0] got);
    nTests++;
    if (got !== exp) begin
      errCount++;
      $display("wrong value readByte expected %h seen %h", exp, got);
    end
  endtask

  task automatic cmpFlags(input logic [1:0] exp);
    nTests++;
    if ({linkDataOe, busy} !== exp) begin
      errCount++;
      $display("wrong value oeBusy expected %b seen %b", exp, {linkDataOe, busy});
    end
  endtask

  task automatic waitIdle();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 40) begin
      @(negedge clk);
      k++;
    end
    if (k == 40) begin
      errCount++;
      $display("wrong value busy expected 0 seen %b", busy);
      closeOut();
    end
  endtask

  task automatic add(input logic [7:0] ins, input logic [7:0] val, input int n,
                     input qpd_wipers_t wp, input logic [7:0] rd);
    rows.push_back('{ins, val, n, wp, rd});
  endtask

  ////////////////////////////////////////
  initial begin
    rst = 1'b1;
    errCount = 0;
    nTests = 0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    cmpFlags(2'b00);
    add(8'hA7, 8'hD5, 8, 24'h000540, 8'h00);
    add(8'h96, 8'h00, 8, 24'h000540, 8'h15);
    add(8'h95, 8'h00, 8, 24'h000540, 8'h15);
    add(8'hC9, 8'h2A, 8, 24'h000540, 8'h00);
    add(8'hC1, 8'h07, 8, 24'h000540, 8'h00);
    add(8'hC5, 8'h3F, 8, 24'h000540, 8'h00);
    add(8'hCD, 8'h11, 8, 24'h000540, 8'h00);
    add(8'hB9, 8'h00, 8, 24'h000540, 8'h2A);
    add(8'hD9, 8'h00, 0, 24'h02A540, 8'h00);
    add(8'h8E, 8'h00, 0, 24'h02A540, 8'h00);
    add(8'h15, 8'h00, 0, 24'h46AFC7, 8'h00);
    add(8'hB6, 8'h00, 8, 24'h46AFC7, 8'h15);
    add(8'hEC, 8'h00, 0, 24'h46AFC7, 8'h00);
    add(8'h12, 8'h00, 0, 24'h02A540, 8'h00);
    add(8'hBC, 8'h00, 8, 24'h02A540, 8'h11);
    add(8'h27, 8'hF4, 8, 24'h02A5C0, 8'h00);
    add(8'hA0, 8'h3E, 8, 24'h02A5FE, 8'h00);
    add(8'h20, 8'hFF, 8, 24'h02A5FF, 8'h00);
    add(8'hA0, 8'h01, 8, 24'h02A5C1, 8'h00);
    add(8'h20, 8'h00, 8, 24'h02A5C0, 8'h00);
    add(8'hA0, 8'h2B, 5, 24'h02A5C0, 8'h00);
    foreach (rows[i]) begin
      qpd_link_master_inst.frame(rows[i].ins, rows[i].val, rows[i].nBits, rdByte);
      waitIdle();
      cmpWiper(rows[i].wp);
      if (rows[i].ins[7:4] inside {4'h9, 4'hB}) begin
        cmpByte(rows[i].rd, rdByte);
      end
    end
    // Every opcode without an operation, each followed by a value byte that must be dropped.
    foreach (badOps[j]) begin
      qpd_link_master_inst.frame({badOps[j], 4'h5}, 8'h2A, 8, rdByte);
      waitIdle();
      cmpWiper(24'h02A5C0);
    end
    cmpFlags(2'b00);
    // Reset lands inside a wiper write and is held to the end of that frame.
    fork
      qpd_link_master_inst.frame(8'hAC, 8'h3F, 8, rdByte);
      begin
        repeat (100) @(negedge clk);
        rst = 1'b1;
      end
    join
    cmpWiper(24'h000000);
    cmpFlags(2'b00);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    // Midway through the read-out the block must drive the line and be done decoding.
    fork
      qpd_link_master_inst.frame(8'hB9, 8'h00, 8, rdByte);
      begin
        repeat (100) @(negedge clk);
        cmpFlags(2'b10);
      end
    join
    cmpByte(8'h2A, rdByte);
    cmpFlags(2'b00);
    closeOut();
  end
endmodule

`default_nettype wire
